// >>> hdl/tt_core.sv
/*
 * Third 16-bit timer/counter core with capture, auto-reload and baud modes,
 * behind an Avalon-MM slave with waitrequest.
 * Assumes count and trigger pins are already synchronous to i_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module tt_core (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic [tt_pkg::TT_ADDR_W-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [tt_pkg::TT_BUS_W-1:0] i_avs_writedata,
	output logic [tt_pkg::TT_BUS_W-1:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic i_count_input_pin,
	input wire logic i_trigger_input_pin,
	output logic o_timer_irq_request,
	output logic o_tx_baud_tick,
	output logic o_rx_baud_tick
);
	import tt_pkg::*;

	tt_state_t st;
	tt_state_t next_st;
	tt_sel_t sel;
	logic running;
	logic baud;
	logic smp;
	logic upd;
	logic cnt_fall;
	logic trig_fall;
	logic inc;
	logic ovf;
	logic trig;
	logic cap;
	logic reload;
	logic wr_go;

	function automatic tt_sel_t decode(input logic [TT_ADDR_W-1:0] a);
		case (a)
			TT_CTRL_OFS: decode = TT_SEL_CTRL;
			TT_CNT_LO_OFS: decode = TT_SEL_CNT_LO;
			TT_CNT_HI_OFS: decode = TT_SEL_CNT_HI;
			TT_HOLD_LO_OFS: decode = TT_SEL_HOLD_LO;
			TT_HOLD_HI_OFS: decode = TT_SEL_HOLD_HI;
			TT_MODE_OFS: decode = TT_SEL_MODE;
			default: decode = TT_SEL_NONE;
		endcase
	endfunction

	function automatic logic [TT_BUS_W-1:0] widen(input logic [7:0] b);
		widen = {24'h00_0000, b};
	endfunction

	always_comb begin
		next_st = st;
		sel = decode(i_avs_address);
		running = st.ctrl[TT_RUN_BIT];
		baud = st.ctrl[TT_TXSEL_BIT] | st.ctrl[TT_RXSEL_BIT];
		smp = (st.phase == TT_SAMPLE_PHASE);
		upd = (st.phase == TT_UPDATE_PHASE);
		// machine cycle of twelve clocks
		next_st.phase = (st.phase == TT_PHASE_LAST) ? 4'h0 : 4'(st.phase + 4'h1);
		// pins sampled once per machine cycle, fall seen across two samples
		cnt_fall = smp & st.cnt_pin_smp & ~i_count_input_pin;
		trig_fall = smp & st.trig_pin_smp & ~i_trigger_input_pin;
		if (smp) begin
			next_st.cnt_pin_smp = i_count_input_pin;
			next_st.trig_pin_smp = i_trigger_input_pin;
		end
		if (upd) begin
			next_st.cnt_pend = 1'b0;
			next_st.trig_pend = 1'b0;
		end
		if (cnt_fall) begin
			next_st.cnt_pend = 1'b1;
		end
		if (trig_fall) begin
			next_st.trig_pend = 1'b1;
		end
		// count source
		if (st.ctrl[TT_CT_BIT]) begin
			inc = running & upd & st.cnt_pend;
		end else if (baud) begin
			inc = running & st.phase[0];
		end else begin
			inc = running & upd;
		end
		ovf = inc & (st.cnt == TT_CNT_MAX);
		trig = running & upd & st.trig_pend & st.ctrl[TT_EXEN_BIT];
		cap = trig & st.ctrl[TT_CPRL_BIT] & ~baud;
		// overflow reload in reload or baud mode, trigger reload in reload mode only
		reload = (ovf & (baud | ~st.ctrl[TT_CPRL_BIT])) | (trig & ~st.ctrl[TT_CPRL_BIT] & ~baud);
		if (reload) begin
			next_st.cnt = st.hold;
		end else if (inc) begin
			next_st.cnt = 16'(st.cnt + 16'h0001);
		end
		if (cap) begin
			next_st.hold = st.cnt;
		end
		// bus slave: one wait cycle, then acknowledge
		next_st.waitreq = ~((i_avs_read | i_avs_write) & st.waitreq);
		wr_go = i_avs_write & ~st.waitreq;
		if (i_avs_read & st.waitreq) begin
			case (sel)
				TT_SEL_CTRL: next_st.rdata = widen(st.ctrl);
				TT_SEL_CNT_LO: next_st.rdata = widen(st.cnt[7:0]);
				TT_SEL_CNT_HI: next_st.rdata = widen(st.cnt[15:8]);
				TT_SEL_HOLD_LO: next_st.rdata = widen(st.hold[7:0]);
				TT_SEL_HOLD_HI: next_st.rdata = widen(st.hold[15:8]);
				TT_SEL_MODE: next_st.rdata = widen({7'h00, st.down_count_enable});
				default: next_st.rdata = TT_RDATA_RST;
			endcase
		end
		if (wr_go) begin
			case (sel)
				TT_SEL_CTRL: begin
					next_st.ctrl[5:0] = i_avs_writedata[5:0];
					if (!i_avs_writedata[TT_OVF_BIT]) begin
						next_st.ctrl[TT_OVF_BIT] = 1'b0;
					end
					if (!i_avs_writedata[TT_EXF_BIT]) begin
						next_st.ctrl[TT_EXF_BIT] = 1'b0;
					end
				end
				TT_SEL_CNT_LO: next_st.cnt[7:0] = i_avs_writedata[7:0];
				TT_SEL_CNT_HI: next_st.cnt[15:8] = i_avs_writedata[7:0];
				TT_SEL_HOLD_LO: next_st.hold[7:0] = i_avs_writedata[7:0];
				TT_SEL_HOLD_HI: next_st.hold[15:8] = i_avs_writedata[7:0];
				TT_SEL_MODE: next_st.down_count_enable = i_avs_writedata[TT_DOWN_COUNT_ENABLE_BIT];
				default: next_st.down_count_enable = st.down_count_enable;
			endcase
		end
		// hardware sets come last so they win over a clear
		if (ovf & ~baud) begin
			next_st.ctrl[TT_OVF_BIT] = 1'b1;
		end
		if (trig) begin
			next_st.ctrl[TT_EXF_BIT] = 1'b1;
		end
		next_st.irq = st.ctrl[TT_OVF_BIT] | (st.ctrl[TT_EXF_BIT] & ~st.down_count_enable);
		next_st.tx_tick = ovf & st.ctrl[TT_TXSEL_BIT];
		next_st.rx_tick = ovf & st.ctrl[TT_RXSEL_BIT];
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st <= TT_STATE_RST;
		end else begin
			st <= next_st;
		end
	end

	assign o_avs_readdata = st.rdata;
	assign o_avs_waitrequest = st.waitreq;
	assign o_timer_irq_request = st.irq;
	assign o_tx_baud_tick = st.tx_tick;
	assign o_rx_baud_tick = st.rx_tick;

	// checks
	logic sw_wr_cnt;
	logic sw_wr_ctrl;
	assign sw_wr_cnt = wr_go & ((sel == TT_SEL_CNT_LO) | (sel == TT_SEL_CNT_HI));
	assign sw_wr_ctrl = wr_go & (sel == TT_SEL_CTRL);

	sequence s_count_fall_seen;
		st.ctrl[TT_CT_BIT] && running && !baud && cnt_fall && !sw_wr_ctrl;
	endsequence

	sequence s_count_applied;
		##1 (upd && inc);
	endsequence

	property p_count_edge_to_update;
		@(posedge i_clk) disable iff (!i_rst_b)
		s_count_fall_seen ##1 (running && st.ctrl[TT_CT_BIT])[*6] |-> s_count_applied;
	endproperty
	a_count_edge_to_update: assert property (p_count_edge_to_update) else $error("fall not counted at update phase");

	property p_count_only_after_fall;
		@(posedge i_clk) disable iff (!i_rst_b)
		(st.ctrl[TT_CT_BIT] && inc) |-> $past(cnt_fall, 7);
	endproperty
	a_count_only_after_fall: assert property (p_count_only_after_fall) else $error("counter stepped without a pin fall");

	property p_timer_once_per_cycle;
		@(posedge i_clk) disable iff (!i_rst_b)
		(running && !st.ctrl[TT_CT_BIT] && !baud && !sw_wr_cnt && !reload)
			|=> st.cnt == ($past(upd) ? 16'($past(st.cnt) + 16'h0001) : $past(st.cnt));
	endproperty
	a_timer_once_per_cycle: assert property (p_timer_once_per_cycle) else $error("timer step off the update phase");

	property p_overflow_flag;
		@(posedge i_clk) disable iff (!i_rst_b)
		(ovf && !baud) |=> st.ctrl[TT_OVF_BIT] ##1 st.irq;
	endproperty
	a_overflow_flag: assert property (p_overflow_flag) else $error("overflow flag or request missing");

	property p_no_flag_in_baud;
		@(posedge i_clk) disable iff (!i_rst_b)
		(baud && !st.ctrl[TT_OVF_BIT]) |=> !st.ctrl[TT_OVF_BIT];
	endproperty
	a_no_flag_in_baud: assert property (p_no_flag_in_baud) else $error("overflow flag set in baud mode");

	property p_baud_tick;
		@(posedge i_clk) disable iff (!i_rst_b)
		(ovf && st.ctrl[TT_TXSEL_BIT] && !sw_wr_cnt) |=> o_tx_baud_tick && st.cnt == $past(st.hold);
	endproperty
	a_baud_tick: assert property (p_baud_tick) else $error("baud overflow without tick or reload");

	property p_capture;
		@(posedge i_clk) disable iff (!i_rst_b)
		cap |=> st.hold == $past(st.cnt) && st.ctrl[TT_EXF_BIT];
	endproperty
	a_capture: assert property (p_capture) else $error("capture did not copy count");

	property p_reload;
		@(posedge i_clk) disable iff (!i_rst_b)
		(reload && !sw_wr_cnt) |=> st.cnt == $past(st.hold);
	endproperty
	a_reload: assert property (p_reload) else $error("reload did not load holding pair");

	property p_stopped;
		@(posedge i_clk) disable iff (!i_rst_b)
		(!running && !sw_wr_cnt) |=> $stable(st.cnt);
	endproperty
	a_stopped: assert property (p_stopped) else $error("count moved while stopped");

	property p_set_wins;
		@(posedge i_clk) disable iff (!i_rst_b)
		(trig && sw_wr_ctrl && !i_avs_writedata[TT_EXF_BIT]) |=> st.ctrl[TT_EXF_BIT];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("clear beat the external flag set");

	property p_down_count_enable_mask;
		@(posedge i_clk) disable iff (!i_rst_b)
		(st.down_count_enable && !st.ctrl[TT_OVF_BIT]) |=> !st.irq;
	endproperty
	a_down_count_enable_mask: assert property (p_down_count_enable_mask) else $error("external flag raised request in down mode");

	property p_bus_answer;
		@(posedge i_clk) disable iff (!i_rst_b)
		((i_avs_read || i_avs_write) && st.waitreq) |=> !st.waitreq ##1 st.waitreq;
	endproperty
	a_bus_answer: assert property (p_bus_answer) else $error("bus answer not one wait cycle");

	property p_overflow_sticky;
		@(posedge i_clk) disable iff (!i_rst_b)
		(st.ctrl[TT_OVF_BIT] && !(sw_wr_ctrl && !i_avs_writedata[TT_OVF_BIT])) |=> st.ctrl[TT_OVF_BIT];
	endproperty
	a_overflow_sticky: assert property (p_overflow_sticky) else $error("overflow flag dropped");

	property p_external_sticky;
		@(posedge i_clk) disable iff (!i_rst_b)
		(st.ctrl[TT_EXF_BIT] && !(sw_wr_ctrl && !i_avs_writedata[TT_EXF_BIT])) |=> st.ctrl[TT_EXF_BIT];
	endproperty
	a_external_sticky: assert property (p_external_sticky) else $error("external flag dropped");

	property p_external_request;
		@(posedge i_clk) disable iff (!i_rst_b)
		(st.ctrl[TT_EXF_BIT] && !st.down_count_enable) |=> st.irq;
	endproperty
	a_external_request: assert property (p_external_request) else $error("external flag gave no request");

	property p_rx_tick;
		@(posedge i_clk) disable iff (!i_rst_b)
		(ovf && st.ctrl[TT_RXSEL_BIT]) |=> o_rx_baud_tick;
	endproperty
	a_rx_tick: assert property (p_rx_tick) else $error("receive baud tick missing");
endmodule
`default_nettype wire

// >>> shared/tt_pkg.sv
/*
 * Constants, register map and state type of the third timer/counter core.
 * Assumes one 50 MHz clock standing in for the oscillator, and a 32-bit Avalon-MM slave bus.
 */
// Notes on behaviour
// - count is high byte plus low byte
// - select bit picks timer or event counter
// - timer counts once per twelve-clock machine cycle, every second clock in baud mode
// - count pin sampled at sample phase, falls counted
// - counted value appears at next update phase
// - external events counted at most osc/24
// - no serial select: cp bit picks reload/capture
// - serial select gives baud mode; run low stops
// - overflow sets sticky overflow flag
// - no overflow flag while serial select set
// - trigger fall causing capture/reload sets external flag
// - external flag raises timer interrupt request
// - down count enable masks external flag interrupt
// - capture mode captures on trigger falls
// - reload mode reloads on overflow and trigger
// - serial select forces reload on overflow
// - capture copies count into holding pair
// - reload loads count from holding pair
// - serial select routes overflow as baud tick
package tt_pkg;
	localparam int TT_BUS_W = 32;
	localparam int TT_ADDR_W = 8;
	localparam logic [7:0] TT_CTRL_OFS = 8'hC8;
	localparam logic [7:0] TT_CNT_LO_OFS = 8'hCC;
	localparam logic [7:0] TT_CNT_HI_OFS = 8'hD0;
	localparam logic [7:0] TT_HOLD_LO_OFS = 8'hD4;
	localparam logic [7:0] TT_HOLD_HI_OFS = 8'hD8;
	localparam logic [7:0] TT_MODE_OFS = 8'hDC;
	// timer_two_control fields, mode register bit, reset and limit values
	localparam int TT_OVF_BIT = 7;
	localparam int TT_EXF_BIT = 6;
	localparam int TT_RXSEL_BIT = 5;
	localparam int TT_TXSEL_BIT = 4;
	localparam int TT_EXEN_BIT = 3;
	localparam int TT_RUN_BIT = 2;
	localparam int TT_CT_BIT = 1;
	localparam int TT_CPRL_BIT = 0;
	localparam int TT_DOWN_COUNT_ENABLE_BIT = 0;
	localparam logic [7:0] TT_CTRL_RST = 8'h00;
	localparam logic [15:0] TT_CNT_RST = 16'h0000;
	localparam logic [15:0] TT_CNT_MAX = 16'hFFFF;
	// machine cycle of twelve clocks, phases 0..11
	localparam logic [3:0] TT_PHASE_LAST = 4'hB;
	localparam logic [3:0] TT_SAMPLE_PHASE = 4'h9;
	localparam logic [3:0] TT_UPDATE_PHASE = 4'h4;
	localparam logic [TT_BUS_W-1:0] TT_RDATA_RST = 32'h0000_0000;

	typedef enum logic [2:0] {
		TT_SEL_NONE = 3'h0,
		TT_SEL_CTRL = 3'h1,
		TT_SEL_CNT_LO = 3'h3,
		TT_SEL_CNT_HI = 3'h2,
		TT_SEL_HOLD_LO = 3'h6,
		TT_SEL_HOLD_HI = 3'h7,
		TT_SEL_MODE = 3'h5
	} tt_sel_t;

	typedef struct packed {
		logic [3:0] phase;
		logic [15:0] cnt;
		logic [15:0] hold;
		logic [7:0] ctrl;
		logic down_count_enable;
		logic cnt_pin_smp;
		logic trig_pin_smp;
		logic cnt_pend;
		logic trig_pend;
		logic waitreq;
		logic [TT_BUS_W-1:0] rdata;
		logic irq;
		logic tx_tick;
		logic rx_tick;
	} tt_state_t;

	localparam tt_state_t TT_STATE_RST = '{
		phase: 4'h0, cnt: TT_CNT_RST, hold: TT_CNT_RST, ctrl: TT_CTRL_RST, down_count_enable: 1'b0,
		cnt_pin_smp: 1'b0, trig_pin_smp: 1'b0, cnt_pend: 1'b0, trig_pend: 1'b0,
		waitreq: 1'b1, rdata: TT_RDATA_RST, irq: 1'b0, tx_tick: 1'b0, rx_tick: 1'b0};
endpackage

// >>> testbench/tt_pins.sv
/*
 * Model of the external count and trigger pin sources.
 * Assumes the sampling clock is the core's i_clk; both pins idle high.
 */
`timescale 1ns/1ps
`default_nettype none
module tt_pins (
	input wire logic i_clk,
	output logic o_count_input_pin,
	output logic o_trigger_input_pin
);
	initial begin
		o_count_input_pin = 1'b1;
		o_trigger_input_pin = 1'b1;
	end
	// one falling edge, each level held two machine cycles
	task fall(input logic which);
		@(posedge i_clk);
		if (which) begin
			o_trigger_input_pin <= 1'b0;
		end else begin
			o_count_input_pin <= 1'b0;
		end
		repeat (24) @(posedge i_clk);
		o_count_input_pin <= 1'b1;
		o_trigger_input_pin <= 1'b1;
		repeat (24) @(posedge i_clk);
	endtask
endmodule
`default_nettype wire

// >>> testbench/tt_core_tb_top.sv
/*
 * Self-checking bench of tt_core: registers, timer, counter/capture and baud modes.
 * Assumes tt_pkg and the pin model tt_pins are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module tt_core_tb_top;
	import tt_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] addr = 8'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic [31:0] q;
	logic wreq, irq, tx_tick, rx_tick, cpin, tpin;
	int fails = 0;
	int checked = 0;
	always #10 clk = ~clk;
	tt_core DUT (.i_clk(clk), .i_rst_b(rst_b), .i_avs_address(addr), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
		.o_avs_waitrequest(wreq), .i_count_input_pin(cpin), .i_trigger_input_pin(tpin),
		.o_timer_irq_request(irq), .o_tx_baud_tick(tx_tick), .o_rx_baud_tick(rx_tick));
	tt_pins PINS (.i_clk(clk), .o_count_input_pin(cpin), .o_trigger_input_pin(tpin));
	task close_out;
		if (fails == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
			fails++;
		end
	endtask
	// one bus cycle, held until waitrequest is seen low
	task bus(input logic [7:0] a, input logic [31:0] d, input logic r);
		int n;
		@(posedge clk);
		addr <= a;
		rd <= r;
		wr <= ~r;
		wdata <= d;
		for (n = 0; n < 20; n++) begin
			@(posedge clk);
			if (wreq === 1'b0) break;
		end
		if (n < 20) begin
			q = rdata;
			rd <= 1'b0;
			wr <= 1'b0;
		end else begin
			fails++;
			close_out();
		end
	endtask
	task rdchk(input logic [7:0] a, input logic [31:0] exp);
		bus(a, 32'h0, 1'b1);
		chk(q, exp);
	endtask
	task sc_regs;
		rdchk(TT_CTRL_OFS, 32'h00);
		rdchk(TT_CNT_HI_OFS, 32'h00);
		rdchk(8'hE0, 32'h00);
	endtask
	task sc_timer;
		bus(TT_CNT_LO_OFS, 32'hFD, 1'b0);
		bus(TT_CNT_HI_OFS, 32'hFF, 1'b0);
		bus(TT_HOLD_LO_OFS, 32'h34, 1'b0);
		bus(TT_HOLD_HI_OFS, 32'h12, 1'b0);
		bus(TT_CTRL_OFS, 32'h04, 1'b0);
		repeat (60) @(posedge clk);
		rdchk(TT_CTRL_OFS, 32'h84);
		rdchk(TT_CNT_HI_OFS, 32'h12);
		@(negedge clk);
		chk({31'h0, irq}, 32'h1);
		bus(TT_CTRL_OFS, 32'h04, 1'b0);
		rdchk(TT_CTRL_OFS, 32'h04);
		bus(TT_CNT_HI_OFS, 32'h00, 1'b0);
		bus(TT_CTRL_OFS, 32'h0C, 1'b0);
		PINS.fall(1'b1);
		rdchk(TT_CNT_HI_OFS, 32'h12);
		rdchk(TT_CTRL_OFS, 32'h4C);
		bus(TT_CTRL_OFS, 32'h00, 1'b0);
	endtask
	task sc_count;
		bus(TT_CNT_LO_OFS, 32'h00, 1'b0);
		bus(TT_CNT_HI_OFS, 32'h00, 1'b0);
		bus(TT_CTRL_OFS, 32'h0F, 1'b0);
		PINS.fall(1'b0);
		PINS.fall(1'b0);
		rdchk(TT_CNT_LO_OFS, 32'h02);
		PINS.fall(1'b1);
		rdchk(TT_HOLD_LO_OFS, 32'h02);
		rdchk(TT_CTRL_OFS, 32'h4F);
		@(negedge clk);
		chk({31'h0, irq}, 32'h1);
		bus(TT_MODE_OFS, 32'h01, 1'b0);
		repeat (2) @(negedge clk);
		chk({31'h0, irq}, 32'h0);
		bus(TT_MODE_OFS, 32'h00, 1'b0);
		bus(TT_CTRL_OFS, 32'h00, 1'b0);
	endtask
	task sc_baud(input logic [7:0] c, input logic use_rx);
		int n;
		bus(TT_HOLD_LO_OFS, 32'hF0, 1'b0);
		bus(TT_HOLD_HI_OFS, 32'hFF, 1'b0);
		bus(TT_CNT_LO_OFS, 32'hF0, 1'b0);
		bus(TT_CNT_HI_OFS, 32'hFF, 1'b0);
		bus(TT_CTRL_OFS, {24'h0, c}, 1'b0);
		for (n = 0; n < 100; n++) begin
			@(negedge clk);
			if ((use_rx ? rx_tick : tx_tick) === 1'b1) break;
		end
		chk({31'h0, n < 100}, 32'h1);
		if (n < 100) begin
			rdchk(TT_CTRL_OFS, {24'h0, c});
			rdchk(TT_CNT_HI_OFS, 32'hFF);
			bus(TT_CTRL_OFS, 32'h00, 1'b0);
		end else begin
			close_out();
		end
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		sc_regs();
		sc_timer();
		sc_count();
		sc_baud(8'h14, 1'b0);
		sc_baud(8'h25, 1'b1);
		close_out();
	end
endmodule
`default_nettype wire
